// file: inc/charger_regs_pkg.sv
// Register map, field layouts and reset values of the charger control bank
package charger_regs_pkg;
    localparam logic [7:0] CHARGE_CONTROL_OFFSET = 8'h01;
    localparam logic [7:0] FLOAT_VOLTAGE_OFFSET = 8'h02;
    localparam logic [7:0] CHIP_ID_OFFSET = 8'h03;
    localparam logic [7:0] CHARGE_CURRENT_OFFSET = 8'h04;
    localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

    localparam logic [7:0] CHARGE_CONTROL_RESET = 8'h30;
    localparam logic [7:0] FLOAT_VOLTAGE_RESET = 8'h0a;
    localparam logic [7:0] CHARGE_CURRENT_RESET = 8'h89;

    localparam int RELOAD_BIT = 7;
    localparam logic CURRENT_RESERVED_VALUE = 1'h1;
    localparam logic RELOAD_READ_VALUE = 1'h1;

    typedef struct packed {
        logic [1:0] input_current_limit_sel;
        logic [1:0] weak_battery_threshold;
        logic termination_enable;
        logic charge_inhibit;
        logic high_impedance_select;
        logic operation_select;
    } charge_control_t;

    typedef struct packed {
        logic [5:0] float_voltage_setting;
        logic host_supply_pin_polarity;
        logic host_supply_pin_enable;
    } float_voltage_and_pin_config_t;

    typedef struct packed {
        logic defaults_reload;
        logic [2:0] max_charge_current_sel;
        logic reserved_one;
        logic [2:0] termination_current_sel;
    } charge_current_config_t;

    typedef struct packed {
        logic [2:0] supplier_field;
        logic [2:0] part_number_field;
        logic [1:0] revision_field;
    } chip_identification_t;

    typedef struct packed {
        logic write_strobe;
        logic read_strobe;
        logic [7:0] address;
        logic [7:0] write_data;
    } reg_request_t;
endpackage

// file: tb/charger_control_register_bank_assertions.sv
// Port assertions of the charger control register bank
`timescale 1ns/1ps
module charger_control_register_bank_assertions #(
    parameter logic [7:0] ID_VALUE = 8'h55
) (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire charger_regs_pkg::reg_request_t reg_request_in,
    input wire charger_regs_pkg::charge_control_t charge_control_out,
    input wire charger_regs_pkg::float_voltage_and_pin_config_t float_voltage_config_out,
    input wire logic [2:0] max_charge_current_sel_out,
    input wire logic [2:0] termination_current_sel_out,
    input wire logic defaults_reload_out,
    input wire logic [7:0] read_data_out,
    input wire logic read_valid_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);
    logic wr;
    logic rd;
    logic [7:0] ad;
    logic [7:0] wd;
    logic reload;
    logic [5:0] cur;
    assign wr = reg_request_in.write_strobe;
    assign rd = reg_request_in.read_strobe;
    assign ad = reg_request_in.address;
    assign wd = reg_request_in.write_data;
    assign reload = wr && ad == 8'h04 && wd[7];
    assign cur = {max_charge_current_sel_out, termination_current_sel_out};
    a_id_read: assert property (rd && ad == 8'h03 |=> read_valid_out && read_data_out == ID_VALUE)
        else $error("identification read wrong");
    a_cur_fixed_bits: assert property (rd && !wr && ad == 8'h04 |=> read_data_out == {1'b1, cur[5:3], 1'b1, cur[2:0]})
        else $error("charge current read wrong");
    a_ctrl_write: assert property (wr && ad == 8'h01 |=> charge_control_out == $past(wd))
        else $error("control write lost");
    a_float_write: assert property (wr && ad == 8'h02 |=> float_voltage_config_out == $past(wd))
        else $error("float write lost");
    a_cur_write: assert property (wr && ad == 8'h04 && !wd[7] |=> cur == {$past(wd[6:4]), $past(wd[2:0])})
        else $error("current write lost");
    a_reload_defaults: assert property (reload |=> defaults_reload_out && charge_control_out == 8'h30 && float_voltage_config_out == 8'h0a && cur == 6'h01)
        else $error("reload wrong");
    a_ctrl_hold: assert property (!(wr && ad == 8'h01) && !reload |=> $stable(charge_control_out))
        else $error("control changed");
    a_reload_cause: assert property (defaults_reload_out |-> $past(reload))
        else $error("reload pulse uncaused");
    c_reload: cover property (reload);
    c_id: cover property (rd && ad == 8'h03);
    c_unmapped: cover property (rd && ad == 8'h05);
endmodule // charger_control_register_bank_assertions

// file: tb/charger_control_register_bank_tb_top.sv
// Self-checking bench of the charger control register bank
`timescale 1ns/1ps
module charger_control_register_bank_tb_top;
    logic sys_clk_in;
    logic rst_b_in;
    charger_regs_pkg::reg_request_t reg_request_in;
    charger_regs_pkg::charge_control_t charge_control_out;
    charger_regs_pkg::float_voltage_and_pin_config_t float_voltage_config_out;
    logic [2:0] max_charge_current_sel_out;
    logic [2:0] termination_current_sel_out;
    logic defaults_reload_out;
    logic [7:0] read_data_out;
    logic read_valid_out;
    logic [7:0] m_ctrl;
    logic [7:0] m_flt;
    logic [7:0] m_cur;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;
    charger_reg_master i_charger_reg_master (.sys_clk_in, .reg_request_out(reg_request_in));
    charger_control_register_bank i_charger_control_register_bank (.sys_clk_in, .rst_b_in,
        .reg_request_in, .charge_control_out, .float_voltage_config_out,
        .max_charge_current_sel_out, .termination_current_sel_out, .defaults_reload_out,
        .read_data_out, .read_valid_out);
    initial begin
        sys_clk_in = 1'b0;
        forever #2.5 sys_clk_in = ~sys_clk_in;
    end
    always @(posedge sys_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            miscompares++;
            stop_test();
        end
    end
    task automatic stop_test();
        if (miscompares == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic logic [7:0] expect_read(input logic [7:0] a);
        case (a)
            8'h01: return m_ctrl;
            8'h02: return m_flt;
            8'h03: return 8'h55;
            8'h04: return m_cur | 8'h88;
            default: return 8'h00;
        endcase
    endfunction
    task automatic defaults();
        m_ctrl = 8'h30;
        m_flt = 8'h0a;
        m_cur = 8'h01;
    endtask
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        i_charger_reg_master.issue(1'b1, a, d);
        if (a == 8'h01) m_ctrl = d;
        if (a == 8'h02) m_flt = d;
        if (a == 8'h04) m_cur = d & 8'h77;
        if (a == 8'h04 && d[7]) defaults();
        check({7'h00, defaults_reload_out}, {7'h00, a == 8'h04 && d[7]});
        check(charge_control_out, m_ctrl);
        check(float_voltage_config_out, m_flt);
        check({2'h0, max_charge_current_sel_out, termination_current_sel_out},
            {2'h0, m_cur[6:4], m_cur[2:0]});
    endtask
    task automatic peek(input logic [7:0] a);
        i_charger_reg_master.issue(1'b0, a, 8'h00);
        check({read_valid_out, read_data_out[7:1]}, {1'b1, 7'(expect_read(a) >> 1)});
        check(read_data_out, expect_read(a));
    endtask
    initial begin
        logic [7:0] a;
        rst_b_in = 1'b0;
        defaults();
        void'($urandom(60));
        repeat (10) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        rst_b_in = 1'b1;
        for (int i = 0; i < 6; i++) peek(i[7:0]);
        put(8'h03, 8'hff);
        peek(8'h03);
        put(8'h04, 8'h7f);
        peek(8'h04);
        put(8'h04, 8'h80);
        peek(8'h01);
        repeat (80) begin
            a = 8'($urandom_range(0, 5));
            put(a, 8'($urandom));
            peek(8'($urandom_range(0, 5)));
        end
        rst_b_in = 1'b0;
        repeat (2) @(negedge sys_clk_in);
        rst_b_in = 1'b1;
        defaults();
        peek(8'h02);
        peek(8'h04);
        stop_test();
    end
endmodule // charger_control_register_bank_tb_top
bind charger_control_register_bank charger_control_register_bank_assertions i_chk (.sys_clk_in,
    .rst_b_in, .reg_request_in, .charge_control_out, .float_voltage_config_out,
    .max_charge_current_sel_out, .termination_current_sel_out, .defaults_reload_out,
    .read_data_out, .read_valid_out);

// file: tb/charger_reg_master.sv
// Register-port master standing in for the serial front end
`timescale 1ns/1ps
module charger_reg_master (
    input wire logic sys_clk_in,
    output charger_regs_pkg::reg_request_t reg_request_out
);
    initial reg_request_out = '0;
    // One-cycle strobe; released lines show inverted values
    task automatic issue(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk_in);
        reg_request_out = {w, ~w, a, d};
        @(negedge sys_clk_in);
        reg_request_out = {2'b00, ~a, ~d};
    endtask
endmodule // charger_reg_master

// file: verilog/charger_control_register_bank.sv
// Register bank of the charger: control, float voltage, identification, charge current
//
// Contract
// - Charge-control register resets to 0x30.
// - Charge-control bits 7:6 hold the read/write input current limit select.
// - Charge-control bits 5:4 hold weak-battery threshold, 3.4V to 3.7V.
// - Charge-control bit 3 enables termination on low charge current.
// - Charge-control bit 2 set disables the charger.
// - Charge-control bit 1 set selects high-impedance mode.
// - Charge-control bit 0 selects charge (0) or boost (1) operation.
// - Offset 0x02 bits 7:2 are float voltage, default code 000010.
// - Offset 0x02 bit 1 sets host-supply pin polarity, 1 active high.
// - Offset 0x02 bit 0 makes the device act on the host-supply pin.
// - Offset 0x03 is read-only identification: supplier, part number, revision.
// - Writing 1 to offset 0x04 bit 7 reloads defaults; reads as 1.
// - Offset 0x04 bits 6:4 select maximum charge current.
// - Offset 0x04 bits 2:0 select the termination current.
// - Charge-current register resets to 0x89.
`timescale 1ns/1ps
module charger_control_register_bank #(
    // Identification values are arbitrary
    parameter logic [2:0] SUPPLIER_CODE = 3'h2,
    parameter logic [2:0] PART_NUMBER_CODE = 3'h5,
    parameter logic [1:0] REVISION_CODE = 2'h1
) (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire charger_regs_pkg::reg_request_t reg_request_in,
    output charger_regs_pkg::charge_control_t charge_control_out,
    output charger_regs_pkg::float_voltage_and_pin_config_t float_voltage_config_out,
    output logic [2:0] max_charge_current_sel_out,
    output logic [2:0] termination_current_sel_out,
    output logic defaults_reload_out,
    output logic [7:0] read_data_out,
    output logic read_valid_out
);
    charger_regs_pkg::charge_control_t charge_control;
    charger_regs_pkg::charge_control_t next_charge_control;
    charger_regs_pkg::float_voltage_and_pin_config_t float_voltage_config;
    charger_regs_pkg::float_voltage_and_pin_config_t next_float_voltage_config;
    charger_regs_pkg::charge_current_config_t charge_current;
    charger_regs_pkg::charge_current_config_t next_charge_current;
    charger_regs_pkg::chip_identification_t chip_identification;
    charger_regs_pkg::charge_current_config_t charge_current_view;
    logic defaults_reload;
    logic next_defaults_reload;
    logic [7:0] read_data;
    logic [7:0] next_read_data;
    logic read_valid;
    logic next_read_valid;
    logic reload_request;

    // Identification is fixed, not stored
    assign chip_identification = '{SUPPLIER_CODE, PART_NUMBER_CODE, REVISION_CODE};

    assign reload_request = reg_request_in.write_strobe
        && reg_request_in.address == charger_regs_pkg::CHARGE_CURRENT_OFFSET
        && reg_request_in.write_data[charger_regs_pkg::RELOAD_BIT];

    always_comb begin
        next_charge_control = charge_control;
        next_float_voltage_config = float_voltage_config;
        next_charge_current = charge_current;
        next_defaults_reload = 1'h0;
        if (reload_request) begin
            // Reload wins over the data written alongside it
            next_charge_control =
                charger_regs_pkg::charge_control_t'(charger_regs_pkg::CHARGE_CONTROL_RESET);
            next_float_voltage_config = charger_regs_pkg::float_voltage_and_pin_config_t'(
                charger_regs_pkg::FLOAT_VOLTAGE_RESET);
            next_charge_current = charger_regs_pkg::charge_current_config_t'(
                charger_regs_pkg::CHARGE_CURRENT_RESET);
            next_defaults_reload = 1'h1;
        end else if (reg_request_in.write_strobe) begin
            unique case (reg_request_in.address)
                charger_regs_pkg::CHARGE_CONTROL_OFFSET: begin
                    // All six fields are read/write
                    next_charge_control = reg_request_in.write_data;
                end
                charger_regs_pkg::FLOAT_VOLTAGE_OFFSET: begin
                    next_float_voltage_config = reg_request_in.write_data;
                end
                charger_regs_pkg::CHARGE_CURRENT_OFFSET: begin
                    next_charge_current.max_charge_current_sel =
                        reg_request_in.write_data[6:4];
                    next_charge_current.termination_current_sel =
                        reg_request_in.write_data[2:0];
                end
                default: begin
                    // Identification and unmapped offsets take no write
                    next_charge_control = charge_control;
                end
            endcase
        end
    end

    // Fixed bits read the same whatever was written
    always_comb begin
        charge_current_view = charge_current;
        charge_current_view.defaults_reload = charger_regs_pkg::RELOAD_READ_VALUE;
        charge_current_view.reserved_one = charger_regs_pkg::CURRENT_RESERVED_VALUE;
    end

    always_comb begin
        next_read_valid = reg_request_in.read_strobe;
        next_read_data = read_data;
        if (reg_request_in.read_strobe) begin
            unique case (reg_request_in.address)
                charger_regs_pkg::CHARGE_CONTROL_OFFSET: begin
                    next_read_data = charge_control;
                end
                charger_regs_pkg::FLOAT_VOLTAGE_OFFSET: begin
                    next_read_data = float_voltage_config;
                end
                charger_regs_pkg::CHIP_ID_OFFSET: begin
                    next_read_data = chip_identification;
                end
                charger_regs_pkg::CHARGE_CURRENT_OFFSET: begin
                    next_read_data = charge_current_view;
                end
                default: begin
                    next_read_data = charger_regs_pkg::UNMAPPED_READ_VALUE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            charge_control <=
                charger_regs_pkg::charge_control_t'(charger_regs_pkg::CHARGE_CONTROL_RESET);
            float_voltage_config <= charger_regs_pkg::float_voltage_and_pin_config_t'(
                charger_regs_pkg::FLOAT_VOLTAGE_RESET);
            charge_current <= charger_regs_pkg::charge_current_config_t'(
                charger_regs_pkg::CHARGE_CURRENT_RESET);
            defaults_reload <= 1'h0;
            read_data <= charger_regs_pkg::UNMAPPED_READ_VALUE;
            read_valid <= 1'h0;
        end else begin
            charge_control <= next_charge_control;
            float_voltage_config <= next_float_voltage_config;
            charge_current <= next_charge_current;
            defaults_reload <= next_defaults_reload;
            read_data <= next_read_data;
            read_valid <= next_read_valid;
        end
    end

    assign charge_control_out = charge_control;
    assign float_voltage_config_out = float_voltage_config;
    assign max_charge_current_sel_out = charge_current.max_charge_current_sel;
    assign termination_current_sel_out = charge_current.termination_current_sel;
    assign defaults_reload_out = defaults_reload;
    assign read_data_out = read_data;
    assign read_valid_out = read_valid;
endmodule // charger_control_register_bank
